// ### verilog/uasm_top.sv
// Alternative setting status, Endpoint1 interface map and Endpoint1 validity.
// Assumes a classic Wishbone master on i_sys_clk and a USB request decoder on
// the same clock that pulses i_set_if_stb once per accepted SET_INTERFACE.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "uasm_regs.svh"

module uasm_top
	import uasm_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int NUM_IF = `UASM_NUM_IF
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_sel,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	output logic o_wb_ack,
	input wire logic i_set_if_stb,
	input wire logic [2:0] i_set_if_index,
	input wire logic [2:0] i_set_if_value,
	input wire logic i_set_if_series5,
	input wire logic i_set_if_series2,
	output logic o_ep1_valid,
	output logic o_irq
);

	logic [7:0] alt_setting_status;
	logic [7:0] endpoint1_interface_map;
	logic [7:0] mode_status_reg;
	logic [7:0] irq_status;
	logic [7:0] irq_enable;
	uasm_setting_t per_interface_setting [NUM_IF];
	logic [15:0] reg_idx;
	logic bus_req;
	logic wr_en;
	logic next_ep1_valid;
	logic [7:0] next_rd;
	logic [7:0] irq_event;
	logic set_if_hit;

	assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign reg_idx = i_wb_adr[17:2];
	assign wr_en = bus_req & i_wb_we & i_wb_sel[0];
	assign set_if_hit = i_set_if_stb & (i_set_if_index < 3'(NUM_IF));

	// Wishbone ack, one cycle after the strobe, dropped the cycle after
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= bus_req;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rd = 8'h00;
		case (reg_idx)
			`UASM_ALT_STATUS_IDX: next_rd = alt_setting_status;
			`UASM_EP1_MAP_IDX: next_rd = endpoint1_interface_map;
			`UASM_IRQ_STATUS_IDX: next_rd = irq_status;
			`UASM_IRQ_ENABLE_IDX: next_rd = irq_enable;
			`UASM_MODE_STATUS_IDX: next_rd = mode_status_reg;
			default: next_rd = 8'h00;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wb_dat <= 32'h0000_0000;
		end else if (bus_req && !i_wb_we) begin
			o_wb_dat <= {24'h00_0000, next_rd};
		end
	end

	// Status only follows SET_INTERFACE; bus writes are not decoded here
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			alt_setting_status <= `UASM_ALT_STATUS_RST;
		end else if (set_if_hit) begin
			if (i_set_if_series5) begin
				alt_setting_status[`UASM_FIVE_MSB:`UASM_FIVE_LSB] <= i_set_if_value;
			end
			if (i_set_if_series2) begin
				alt_setting_status[`UASM_TWO_BIT] <= i_set_if_value[0];
			end
		end
	end

	// Per-interface setting copies
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < NUM_IF; i++) begin
				per_interface_setting[i] <= 3'h0;
			end
		end else if (set_if_hit) begin
			per_interface_setting[i_set_if_index] <= i_set_if_value;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			endpoint1_interface_map <= `UASM_EP1_MAP_RST;
		end else if (wr_en && reg_idx == `UASM_EP1_MAP_IDX) begin
			endpoint1_interface_map <= i_wb_dat[7:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_status_reg <= `UASM_MODE_RST;
		end else if (wr_en && reg_idx == `UASM_MODE_STATUS_IDX) begin
			mode_status_reg <= i_wb_dat[7:0];
		end
	end

	// Endpoint1 validity from link code, enables and linked setting
	always_comb begin
		uasm_link_t code;
		uasm_setting_t cur;
		logic [3:0] five_en;
		logic linked;
		code = uasm_link_t'(endpoint1_interface_map[`UASM_LINK_MSB:`UASM_LINK_LSB]);
		five_en = endpoint1_interface_map[3:0];
		cur = 3'h0;
		linked = 1'b0;
		case (code)
			UASM_LINK_IF0, UASM_LINK_IF1, UASM_LINK_IF2,
			UASM_LINK_IF3, UASM_LINK_IF4: begin
				linked = 1'b1;
				cur = per_interface_setting[code - 3'h1];
			end
			default: linked = 1'b0;
		endcase
		next_ep1_valid = 1'b0;
		if (linked && mode_status_reg[`UASM_CONFIGURED_FLAG_BIT]) begin
			if (cur == 3'h0) begin
				next_ep1_valid = 1'b1;
			end else if (five_en != 4'h0) begin
				if (cur <= 3'h4) begin
					next_ep1_valid = five_en[2'(cur - 3'h1)];
				end
			end else if (cur == 3'h1) begin
				next_ep1_valid = endpoint1_interface_map[`UASM_TWO_EN_BIT];
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ep1_valid <= 1'b0;
		end else begin
			o_ep1_valid <= next_ep1_valid;
		end
	end

	// Interrupt events: set-interface and Endpoint1 validity change
	always_comb begin
		irq_event = 8'h00;
		irq_event[`UASM_IRQ_SETIF_BIT] = set_if_hit;
		irq_event[`UASM_IRQ_EP1CHG_BIT] = next_ep1_valid ^ o_ep1_valid;
	end

	// Sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_status <= `UASM_IRQ_RST;
		end else if (wr_en && reg_idx == `UASM_IRQ_CLEAR_IDX) begin
			irq_status <= (irq_status & ~i_wb_dat[7:0]) | irq_event;
		end else begin
			irq_status <= irq_status | irq_event;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_enable <= `UASM_IRQ_RST;
		end else if (wr_en && reg_idx == `UASM_IRQ_ENABLE_IDX) begin
			irq_enable <= i_wb_dat[7:0];
		end
	end

	assign o_irq = |(irq_status & irq_enable);

	// Checks
	logic [2:0] chk_code;
	logic [2:0] chk_cur;
	logic chk_configured_flag;
	assign chk_code = endpoint1_interface_map[7:5];
	assign chk_cur = (chk_code >= 3'h1 && chk_code <= 3'h5) ? per_interface_setting[chk_code - 3'h1] : 3'h0;
	assign chk_configured_flag = mode_status_reg[0];

	property p_status_ro;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(wr_en && reg_idx == `UASM_ALT_STATUS_IDX && !set_if_hit) |=> $stable(alt_setting_status);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status changed by bus write");

	property p_five_update;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(set_if_hit && i_set_if_series5) |=> (alt_setting_status[3:1] == $past(i_set_if_value));
	endproperty
	a_five_update: assert property (p_five_update) else $error("five-series field not updated");

	property p_two_update;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(set_if_hit && i_set_if_series2) |=> (alt_setting_status[0] == $past(i_set_if_value[0]));
	endproperty
	a_two_update: assert property (p_two_update) else $error("two-series bit not updated");

	property p_if_copy;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		set_if_hit |=> (per_interface_setting[$past(i_set_if_index)] == $past(i_set_if_value));
	endproperty
	a_if_copy: assert property (p_if_copy) else $error("interface setting not stored");

	property p_map_write;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(wr_en && reg_idx == `UASM_EP1_MAP_IDX) |=> (endpoint1_interface_map == $past(i_wb_dat[7:0]));
	endproperty
	a_map_write: assert property (p_map_write) else $error("map write lost");

	// Read data carries the status value seen at the taking edge
	property p_status_read;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(bus_req && !i_wb_we && reg_idx == `UASM_ALT_STATUS_IDX)
			|=> (o_wb_dat[7:0] == $past(alt_setting_status));
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read data wrong");

	// A set-interface event is never lost to a clear in the same cycle
	property p_irq_set_wins;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		set_if_hit |=> irq_status[`UASM_IRQ_SETIF_BIT];
	endproperty
	a_irq_set_wins: assert property (p_irq_set_wins) else $error("set-interface event lost");

	property p_unlinked;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(chk_code[2:1] == 2'b11 || chk_code == 3'h0) |=> !o_ep1_valid;
	endproperty
	a_unlinked: assert property (p_unlinked) else $error("unlinked endpoint valid");

	property p_configured_flag_needed;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!chk_configured_flag |=> !o_ep1_valid;
	endproperty
	a_configured_flag_needed: assert property (p_configured_flag_needed) else $error("valid without configured flag");

	property p_base_valid;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(chk_code >= 3'h1 && chk_code <= 3'h5 && chk_configured_flag && chk_cur == 3'h0) |=> o_ep1_valid;
	endproperty
	a_base_valid: assert property (p_base_valid) else $error("linked endpoint not valid");

	property p_two_en;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(chk_code >= 3'h1 && chk_code <= 3'h5 && chk_configured_flag && chk_cur == 3'h1
			&& endpoint1_interface_map[3:0] == 4'h0) |=> (o_ep1_valid == $past(endpoint1_interface_map[4]));
	endproperty
	a_two_en: assert property (p_two_en) else $error("two-series enable ignored");

	property p_five_en;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(chk_code >= 3'h1 && chk_code <= 3'h5 && chk_configured_flag && chk_cur >= 3'h1 && chk_cur <= 3'h4
			&& endpoint1_interface_map[3:0] != 4'h0)
			|=> (o_ep1_valid == $past(endpoint1_interface_map[2'(chk_cur - 3'h1)]));
	endproperty
	a_five_en: assert property (p_five_en) else $error("five-series enable ignored");

	property p_irq_setif;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(set_if_hit && irq_enable[0]) |=> o_irq;
	endproperty
	a_irq_setif: assert property (p_irq_setif) else $error("set-interface interrupt missing");

	property p_ack_pulse;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

	c_set_if: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) set_if_hit ##1 o_irq);
	c_valid_five: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_ep1_valid && chk_cur == 3'h3);
	c_valid_two: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_ep1_valid && chk_cur == 3'h1 && endpoint1_interface_map[3:0] == 4'h0);
	c_clear_race: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		set_if_hit && wr_en && reg_idx == `UASM_IRQ_CLEAR_IDX);

endmodule

// ### common/uasm_regs.svh
// Register indices, field positions and reset values of the alternative
// setting status and Endpoint1 mapping block. Byte address is index times four.
`ifndef UASM_REGS_SVH
`define UASM_REGS_SVH

`define UASM_ALT_STATUS_IDX 16'hff72
`define UASM_EP1_MAP_IDX 16'hff73
`define UASM_IRQ_STATUS_IDX 16'hff80
`define UASM_IRQ_ENABLE_IDX 16'hff81
`define UASM_IRQ_CLEAR_IDX 16'hff82
`define UASM_MODE_STATUS_IDX 16'hff83

`define UASM_FIVE_LSB 1
`define UASM_FIVE_MSB 3
`define UASM_TWO_BIT 0
`define UASM_LINK_LSB 5
`define UASM_LINK_MSB 7
`define UASM_TWO_EN_BIT 4
`define UASM_CONFIGURED_FLAG_BIT 0
`define UASM_IRQ_SETIF_BIT 0
`define UASM_IRQ_EP1CHG_BIT 1

`define UASM_ALT_STATUS_RST 8'h00
`define UASM_EP1_MAP_RST 8'h00
`define UASM_IRQ_RST 8'h00
`define UASM_MODE_RST 8'h00
`define UASM_NUM_IF 5

`endif

// ### common/uasm_pkg.sv
// Types shared by the alternative setting status block.
// Assumes the register header is included by the design files.
package uasm_pkg;
	typedef logic [2:0] uasm_setting_t;
	typedef enum logic [2:0] {
		UASM_LINK_NONE = 3'b000,
		UASM_LINK_IF0 = 3'b001,
		UASM_LINK_IF1 = 3'b010,
		UASM_LINK_IF2 = 3'b011,
		UASM_LINK_IF3 = 3'b100,
		UASM_LINK_IF4 = 3'b101,
		UASM_LINK_OFF6 = 3'b110,
		UASM_LINK_OFF7 = 3'b111
	} uasm_link_t;
endpackage

// ### sim/uasm_host.sv
// Host model: issues SET_INTERFACE requests as decoder strobes.
// Assumes the caller sits on the same clock as the block.
`timescale 1ns/10ps

module uasm_host (
	input wire logic i_sys_clk,
	output logic o_stb,
	output logic [2:0] o_index,
	output logic [2:0] o_value,
	output logic o_series5,
	output logic o_series2
);
	initial begin
		o_stb = 1'b0;
		o_index = 3'h7;
		o_value = 3'h0;
		o_series5 = 1'b0;
		o_series2 = 1'b0;
	end

	task automatic send(input logic [2:0] idx, input logic [2:0] v, input logic s5, input logic s2);
		@(posedge i_sys_clk);
		o_stb <= 1'b1;
		o_index <= idx;
		o_value <= v;
		o_series5 <= s5;
		o_series2 <= s2;
		@(posedge i_sys_clk);
		// Released qualifiers show the complement of the last request, not the request itself
		o_stb <= 1'b0;
		o_index <= ~idx;
		o_value <= ~v;
		o_series5 <= ~s5;
		o_series2 <= ~s2;
	endtask
endmodule

// ### sim/uasm_top_bench.sv
// Self-checking bench for the status and Endpoint1 map block.
// Assumes the host model and the register header on the include path.
`timescale 1ns/10ps
`include "uasm_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end

module uasm_top_bench;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [17:0] adr = '0;
	logic [31:0] wdat = '0;
	logic [31:0] rdat;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic ack, ep1_valid, irq, h_stb, h_s5, h_s2;
	logic [2:0] h_idx, h_val;
	logic [2:0] sets [5];
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;

	always #4 i_sys_clk = ~i_sys_clk;

	uasm_host uasm_host_i (.i_sys_clk(i_sys_clk), .o_stb(h_stb), .o_index(h_idx), .o_value(h_val),
		.o_series5(h_s5), .o_series2(h_s2));

	uasm_top uasm_top_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wb_adr(adr), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .i_wb_we(we), .i_wb_sel(4'hf), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_ack(ack),
		.i_set_if_stb(h_stb), .i_set_if_index(h_idx), .i_set_if_value(h_val), .i_set_if_series5(h_s5),
		.i_set_if_series2(h_s2), .o_ep1_valid(ep1_valid), .o_irq(irq));

	task automatic end_of_test();
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic ep1_exp(input logic [7:0] m, input logic c);
		logic [2:0] s;
		if (m[7:5] == 3'b000 || m[7:5] > 3'b101 || !c)
			return 1'b0;
		s = sets[m[7:5] - 3'd1];
		if (s == 3'd0)
			return 1'b1;
		if (m[3:0] != 4'h0)
			return m[s - 3'd1];
		return m[4] && s == 3'd1;
	endfunction

	task automatic wb(input logic [15:0] idx, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(posedge i_sys_clk);
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge i_sys_clk);
		end while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	initial begin
		logic [31:0] r;
		logic [7:0] q, map, st;
		logic [2:0] ix, v;
		logic s5;
		r = 32'h45ccd91c;
		st = 8'h00;
		for (int k = 0; k < 5; k++)
			sets[k] = 3'h0;
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		wb(`UASM_EP1_MAP_IDX, 1'b0, 8'h00, q);
		`CHK(q, 8'h00)
		wb(`UASM_ALT_STATUS_IDX, 1'b1, 8'hff, q);
		wb(`UASM_ALT_STATUS_IDX, 1'b0, 8'h00, q);
		`CHK(q, 8'h00)
		wb(16'h0100, 1'b0, 8'h00, q);
		`CHK(q, 8'h00)
		for (int i = 0; i < 40; i++) begin
			r = lfsr(r);
			ix = 3'(r[2:0] % 5);
			v = 3'(r[5:3] % 5);
			map = r[15:8];
			if (i < 2)
				map = {i ? 3'b111 : 3'b110, 5'h1f};
			if (i == 2) begin
				map = 8'h30;
				ix = 3'd0;
				v = 3'd1;
			end
			wb(`UASM_EP1_MAP_IDX, 1'b1, map, q);
			wb(`UASM_MODE_STATUS_IDX, 1'b1, {7'h0, r[16] | (i < 3)}, q);
			s5 = r[7] | (i < 3);
			uasm_host_i.send(ix, v, s5, r[6]);
			sets[ix] = v;
			st = {4'h0, s5 ? v : st[3:1], r[6] ? v[0] : st[0]};
			repeat (3) @(posedge i_sys_clk);
			`CHK(ep1_valid, ep1_exp(map, r[16] | (i < 3)))
			wb(`UASM_ALT_STATUS_IDX, 1'b0, 8'h00, q);
			`CHK(q, st)
			wb(`UASM_EP1_MAP_IDX, 1'b0, 8'h00, q);
			`CHK(q, map)
		end
		uasm_host_i.send(3'd5, 3'd3, 1'b1, 1'b1);
		wb(`UASM_ALT_STATUS_IDX, 1'b0, 8'h00, q);
		`CHK(q, st)
		wb(`UASM_IRQ_CLEAR_IDX, 1'b1, 8'hff, q);
		wb(`UASM_IRQ_ENABLE_IDX, 1'b1, 8'h01, q);
		`CHK(irq, 1'b0)
		uasm_host_i.send(3'd2, 3'd4, 1'b1, 1'b0);
		repeat (2) @(posedge i_sys_clk);
		`CHK(irq, 1'b1)
		wb(`UASM_ALT_STATUS_IDX, 1'b0, 8'h00, q);
		`CHK(q, {4'h0, 3'd4, st[0]})
		wb(`UASM_IRQ_CLEAR_IDX, 1'b1, 8'h01, q);
		@(posedge i_sys_clk);
		`CHK(irq, 1'b0)
		wb(`UASM_IRQ_ENABLE_IDX, 1'b1, 8'h00, q);
		uasm_host_i.send(3'd1, 3'd2, 1'b1, 1'b0);
		repeat (2) @(posedge i_sys_clk);
		`CHK(irq, 1'b0)
		wb(`UASM_IRQ_STATUS_IDX, 1'b0, 8'h00, q);
		`CHK(q[0], 1'b1)
		end_of_test();
	end
endmodule
